// [core/scicsl_core.v]
// Control, status, transmitter and receiver logic of the asynchronous serial interface.
//
// Added by the designer: strobed register access and the address map.
`include "scicsl_regs.vh"
module scicsl_core (
	input wire ref_clk_i,
	input wire rstn_i,
	input wire [2:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire tx_tick_i,
	input wire rx_tick_i,
	input wire rx_pin_i,
	output reg tx_pin_o,
	output reg tx_irq_o,
	output reg rx_irq_o,
	output reg err_irq_o
);
	reg [7:0] c1_q;
	reg [7:0] c2_q;
	reg [3:0] err_en_q;
	reg txe_q, tc_q, rxf_q, idle_q, ovr_q, nse_q, frm_q, par_q;
	reg [7:0] snap_q;
	reg [7:0] tx_data_q;
	reg tx_ninth_q;
	reg [7:0] rx_data_q;
	reg rx_ninth_q;
	reg tx_busy_q, pre_pend_q, brk_pend_q, after_brk_q;
	reg [10:0] tx_sh_q;
	reg [3:0] tx_cnt_q;
	reg rx_s1_q, rx_s2_q;
	reg [1:0] rx_st_q;
	reg [3:0] rx_ph_q;
	reg [3:0] rx_bit_q;
	reg [10:0] rx_sh_q;
	reg smp_a_q, smp_b_q, nacc_q;
	reg [7:0] idle_cnt_q;
	reg idle_arm_q;
	wire en = c1_q[`SCICSL_C1_ENABLE];
	wire nine = c1_q[`SCICSL_C1_NINE];
	wire pen = c1_q[`SCICSL_C1_PEN];
	wire podd = c1_q[`SCICSL_C1_PODD];
	wire tx_on = c2_q[`SCICSL_C2_TX_ON];
	wire rx_on = c2_q[`SCICSL_C2_RX_ON];
	wire stby = c2_q[`SCICSL_C2_STBY];
	wire send_break_ctl = c2_q[`SCICSL_C2_BRK];
	wire [3:0] flen = nine ? `SCICSL_LEN9 : `SCICSL_LEN8;
	wire [7:0] idle_lim = nine ? `SCICSL_IDLE9 : `SCICSL_IDLE8;
	wire [7:0] stat = {txe_q, tc_q, rxf_q, idle_q, ovr_q, nse_q, frm_q, par_q};
	wire wr_c2 = wr_i && (addr_i == `SCICSL_OFS_CTRL_TWO);
	wire rd_st = rd_i && (addr_i == `SCICSL_OFS_STATUS_ONE);
	wire rd_dat = rd_i && (addr_i == `SCICSL_OFS_DATA);
	wire wr_dat = wr_i && (addr_i == `SCICSL_OFS_DATA);

	// Transmit frame: start bit, data with optional parity, ninth bit, stop bit, LSB first.
	wire tx_par = (nine ? ^tx_data_q : ^tx_data_q[6:0]) ^ podd;
	wire tx_b7 = (pen && !nine) ? tx_par : tx_data_q[7];
	wire tx_b8 = pen ? tx_par : tx_ninth_q;
	wire [10:0] tx_frame = nine ? {1'b1, tx_b8, tx_b7, tx_data_q[6:0], 1'b0} : {2'b11, tx_b7, tx_data_q[6:0], 1'b0};
	wire tx_slot = tx_tick_i && (!tx_busy_q || tx_cnt_q == 4'h0);
	wire tx_go = en && tx_on;
	wire ld_brk = tx_slot && tx_go && (send_break_ctl || brk_pend_q);
	wire ld_one = tx_slot && tx_go && !ld_brk && after_brk_q;
	wire ld_pre = tx_slot && tx_go && !ld_brk && !ld_one && pre_pend_q;
	wire ld_dat = tx_slot && tx_go && !ld_brk && !ld_one && !ld_pre && !txe_q;

	// Receiver sampling: majority of three mid-bit samples.
	wire rx_run = en && rx_on;
	wire rx_in = rx_s2_q;
	wire maj = (smp_a_q & smp_b_q) | (smp_a_q & rx_in) | (smp_b_q & rx_in);
	wire noisy = !((smp_a_q == smp_b_q) && (smp_b_q == rx_in));
	wire rx_dec = rx_run && rx_tick_i && rx_st_q == `SCICSL_ST_RECV && rx_ph_q == `SCICSL_PH_C;
	wire rx_last = rx_dec && rx_bit_q != 4'h0 && rx_bit_q == flen - 4'h1;
	wire [10:0] rx_v = {maj, rx_sh_q[10:1]};
	wire [7:0] rx_byte = nine ? rx_v[8:1] : rx_v[9:2];
	wire rx_msb = nine ? rx_v[9] : rx_v[9];
	wire rx_perr = (nine ? (^rx_v[8:1] ^ rx_v[9]) : ^rx_v[9:2]) ^ podd;
	wire addr_wake = stby && c1_q[`SCICSL_C1_WAKE] && rx_msb;
	wire rx_take = rx_last && (!stby || addr_wake);
	wire rx_store = rx_take && !rxf_q;
	wire idle_hit = rx_run && rx_tick_i && rx_in && rx_st_q == `SCICSL_ST_HUNT && idle_cnt_q == idle_lim - 8'h01;

	// Control registers and the two-step flag snapshot.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			c1_q <= `SCICSL_RST_C1;
			c2_q <= `SCICSL_RST_C2;
			err_en_q <= `SCICSL_RST_EN;
			snap_q <= 8'h00;
		end else begin
			if (wr_i && addr_i == `SCICSL_OFS_CTRL_ONE)
				c1_q <= wdata_i;
			if (wr_c2) begin
				c2_q[7:4] <= wdata_i[7:4];
				c2_q[1:0] <= wdata_i[1:0];
				if (en) begin
					c2_q[`SCICSL_C2_TX_ON] <= wdata_i[`SCICSL_C2_TX_ON];
					c2_q[`SCICSL_C2_RX_ON] <= wdata_i[`SCICSL_C2_RX_ON];
				end
			end
			// A wake event ends standby; it overrides a write in the same cycle.
			if (stby && (addr_wake && rx_last || idle_hit && !c1_q[`SCICSL_C1_WAKE]))
				c2_q[`SCICSL_C2_STBY] <= 1'b0;
			if (wr_i && addr_i == `SCICSL_OFS_CTRL_THREE)
				err_en_q <= wdata_i[3:0];
			if (rd_st)
				snap_q <= stat;
			else begin
				if (rd_dat)
					snap_q[5:0] <= 6'h00;
				if (wr_dat)
					snap_q[`SCICSL_S_TXE] <= 1'b0;
			end
		end
	end

	// Data and ninth bits are not touched by reset.
	always @(posedge ref_clk_i) begin
		if (wr_dat)
			tx_data_q <= wdata_i;
		if (wr_i && addr_i == `SCICSL_OFS_CTRL_THREE)
			tx_ninth_q <= wdata_i[`SCICSL_C3_T8];
		if (rx_store) begin
			rx_data_q <= rx_byte;
			rx_ninth_q <= rx_msb;
		end
	end

	// Transmitter engine.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_pin_o <= 1'b1;
			tx_busy_q <= 1'b0;
			tx_sh_q <= 11'h7FF;
			tx_cnt_q <= 4'h0;
			pre_pend_q <= 1'b0;
			brk_pend_q <= 1'b0;
			after_brk_q <= 1'b0;
			txe_q <= 1'b1;
			tc_q <= 1'b1;
		end else if (!en) begin
			tx_pin_o <= 1'b1;
			tx_busy_q <= 1'b0;
			tx_cnt_q <= 4'h0;
			pre_pend_q <= 1'b0;
			brk_pend_q <= 1'b0;
			after_brk_q <= 1'b0;
			txe_q <= 1'b1;
			tc_q <= 1'b1;
		end else begin
			if (tx_tick_i && tx_busy_q && tx_cnt_q != 4'h0) begin
				tx_pin_o <= tx_sh_q[0];
				tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				tx_cnt_q <= tx_cnt_q - 4'h1;
			end else if (tx_slot) begin
				// The shifter keeps running with the transmitter off, so a character is cut only by clearing the module enable.
				tx_busy_q <= ld_brk | ld_one | ld_pre | ld_dat;
				tx_pin_o <= ld_brk ? 1'b0 : ld_dat ? tx_frame[0] : 1'b1;
				tx_sh_q <= ld_brk ? 11'h000 : ld_dat ? {1'b1, tx_frame[10:1]} : 11'h7FF;
				tx_cnt_q <= ld_one ? 4'h0 : (ld_brk | ld_pre | ld_dat) ? flen - 4'h1 : 4'h0;
			end
			if (ld_brk) begin
				brk_pend_q <= 1'b0;
				pre_pend_q <= 1'b0;
				after_brk_q <= 1'b1;
			end
			if (ld_one)
				after_brk_q <= 1'b0;
			if (ld_pre)
				pre_pend_q <= 1'b0;
			if (wr_c2 && !tx_on && wdata_i[`SCICSL_C2_TX_ON])
				pre_pend_q <= 1'b1;
			if (wr_c2 && send_break_ctl && !wdata_i[`SCICSL_C2_BRK])
				brk_pend_q <= 1'b1;
			if (wr_dat && snap_q[`SCICSL_S_TXE])
				txe_q <= 1'b0;
			if (ld_dat)
				txe_q <= 1'b1;
			// A data write that fills the buffer this cycle must not leave complete set beside it.
			tc_q <= txe_q && !ld_dat && !tx_busy_q && !pre_pend_q && !brk_pend_q && !after_brk_q
				&& !(wr_dat && snap_q[`SCICSL_S_TXE])
				&& !(send_break_ctl && tx_on) && !(tx_slot && tx_go);
		end
	end

	// Receiver input synchroniser, bit sampler and idle counter.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_st_q <= `SCICSL_ST_HUNT;
			rx_ph_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 11'h000;
			smp_a_q <= 1'b1;
			smp_b_q <= 1'b1;
			nacc_q <= 1'b0;
			idle_cnt_q <= 8'h00;
			idle_arm_q <= 1'b0;
		end else begin
			rx_s1_q <= rx_pin_i;
			rx_s2_q <= rx_s1_q;
			if (!rx_run) begin
				// Stops the receiver only; the flags keep their values.
				rx_st_q <= `SCICSL_ST_HUNT;
				idle_cnt_q <= 8'h00;
				idle_arm_q <= 1'b0;
			end else if (rx_tick_i) begin
				case (rx_st_q)
				`SCICSL_ST_HUNT: begin
					if (!rx_in) begin
						rx_st_q <= `SCICSL_ST_RECV;
						rx_ph_q <= 4'h1;
						rx_bit_q <= 4'h0;
						nacc_q <= 1'b0;
						idle_cnt_q <= 8'h00;
					end else if (idle_cnt_q != idle_lim)
						idle_cnt_q <= idle_cnt_q + 8'h01;
				end
				`SCICSL_ST_RECV: begin
					rx_ph_q <= rx_ph_q + 4'h1;
					if (rx_ph_q == `SCICSL_PH_A)
						smp_a_q <= rx_in;
					if (rx_ph_q == `SCICSL_PH_B)
						smp_b_q <= rx_in;
					if (rx_dec) begin
						rx_sh_q <= rx_v;
						rx_bit_q <= rx_bit_q + 4'h1;
						nacc_q <= nacc_q | noisy;
						if (rx_bit_q == 4'h0 && maj)
							rx_st_q <= `SCICSL_ST_HUNT;
						if (rx_last)
							rx_st_q <= `SCICSL_ST_HUNT;
					end
				end
				default: rx_st_q <= `SCICSL_ST_HUNT;
				endcase
			end
			if (rx_run && rx_store)
				idle_arm_q <= 1'b1;
			if (idle_hit)
				idle_arm_q <= 1'b0;
		end
	end

	// Receiver flags: the read clear applies only to flags seen by the status read; a set wins.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rxf_q <= 1'b0;
			idle_q <= 1'b0;
			ovr_q <= 1'b0;
			nse_q <= 1'b0;
			frm_q <= 1'b0;
			par_q <= 1'b0;
		end else begin
			if (rd_dat) begin
				rxf_q <= rxf_q & ~snap_q[`SCICSL_S_RXF];
				idle_q <= idle_q & ~snap_q[`SCICSL_S_IDLE];
				ovr_q <= ovr_q & ~snap_q[`SCICSL_S_OVR];
				nse_q <= nse_q & ~snap_q[`SCICSL_S_NSE];
				frm_q <= frm_q & ~snap_q[`SCICSL_S_FRM];
				par_q <= par_q & ~snap_q[`SCICSL_S_PAR];
			end
			if (rx_take && rxf_q)
				ovr_q <= 1'b1;
			if (rx_store) begin
				rxf_q <= 1'b1;
				if (nacc_q | noisy)
					nse_q <= 1'b1;
				if (!maj)
					frm_q <= 1'b1;
				if (pen && rx_perr)
					par_q <= 1'b1;
			end
			if (idle_hit && idle_arm_q)
				idle_q <= 1'b1;
		end
	end

	// Register read port and interrupt requests.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
			tx_irq_o <= 1'b0;
			rx_irq_o <= 1'b0;
			err_irq_o <= 1'b0;
		end else begin
			case (addr_i)
			`SCICSL_OFS_CTRL_ONE: rdata_o <= rd_i ? c1_q : 8'h00;
			`SCICSL_OFS_CTRL_TWO: rdata_o <= rd_i ? c2_q : 8'h00;
			`SCICSL_OFS_CTRL_THREE: rdata_o <= rd_i ? {rx_ninth_q, tx_ninth_q, 2'b00, err_en_q} : 8'h00;
			`SCICSL_OFS_STATUS_ONE: rdata_o <= rd_i ? stat : 8'h00;
			`SCICSL_OFS_DATA: rdata_o <= rd_i ? rx_data_q : 8'h00;
			default: rdata_o <= 8'h00;
			endcase
			tx_irq_o <= en && (c2_q[`SCICSL_C2_TXE_IE] && txe_q || c2_q[`SCICSL_C2_TC_IE] && tc_q);
			rx_irq_o <= !stby && (c2_q[`SCICSL_C2_RXF_IE] && rxf_q || c2_q[`SCICSL_C2_IDLE_IE] && idle_q);
			err_irq_o <= |(err_en_q & stat[3:0]);
		end
	end
endmodule

// [core/scicsl_regs.vh]
// Register map, field positions and fixed counts of the serial control and status logic.
// Functional notes
// - Transmission-complete flag raises transmitter interrupt when enabled.
// - Receive-full or idle raise receiver interrupt.
// - Enabling transmitter first sends all-ones preamble.
// - Disabling transmitter finishes current character first.
// - Re-enabling mid-character queues one idle character.
// - Transmitter and receiver enable bits ignore writes while module disabled.
// - Receiver disable keeps receiver flags unchanged.
// - Standby suppresses receiver interrupts; wake clears it.
// - Break toggle sends break plus one bit.
// - Break toggle replaces a pending preamble.
// - Received ninth bit or bit seven captured.
// - Transmit ninth bit loads with data byte.
// - Four error enables gate shared error interrupt.
// - Transmit-empty sets on transfer, two-step clear.
// - Transmission-complete set when nothing is being sent.
// - Receive-full sets on transfer, two-step clear.
// - Idle sets after a character of ones.
// - Idle armed only after a received character.
// - Overrun keeps old byte, drops new one.
// - Overrun clears only if seen before.
// - Noise flag sets on disagreeing samples.
// - Framing flag sets on zero stop bit.
// - Parity flag sets on parity mismatch.
// - Module disable forces empty and complete flags.
`ifndef SCICSL_REGS_VH
`define SCICSL_REGS_VH
`define SCICSL_AW 3
`define SCICSL_OFS_CTRL_ONE 3'h0
`define SCICSL_OFS_CTRL_TWO 3'h1
`define SCICSL_OFS_CTRL_THREE 3'h2
`define SCICSL_OFS_STATUS_ONE 3'h3
`define SCICSL_OFS_DATA 3'h4
// ctrl_one fields
`define SCICSL_C1_ENABLE 6
`define SCICSL_C1_NINE 4
`define SCICSL_C1_WAKE 3
`define SCICSL_C1_PEN 1
`define SCICSL_C1_PODD 0
// ctrl_two fields
`define SCICSL_C2_TXE_IE 7
`define SCICSL_C2_TC_IE 6
`define SCICSL_C2_RXF_IE 5
`define SCICSL_C2_IDLE_IE 4
`define SCICSL_C2_TX_ON 3
`define SCICSL_C2_RX_ON 2
`define SCICSL_C2_STBY 1
`define SCICSL_C2_BRK 0
// ctrl_three fields
`define SCICSL_C3_R8 7
`define SCICSL_C3_T8 6
// status_one fields, error enables in ctrl_three share positions 3..0
`define SCICSL_S_TXE 7
`define SCICSL_S_TC 6
`define SCICSL_S_RXF 5
`define SCICSL_S_IDLE 4
`define SCICSL_S_OVR 3
`define SCICSL_S_NSE 2
`define SCICSL_S_FRM 1
`define SCICSL_S_PAR 0
`define SCICSL_RST_C1 8'h00
`define SCICSL_RST_C2 8'h00
`define SCICSL_RST_EN 4'h0
// Frame lengths in bits and receiver oversampling.
`define SCICSL_LEN8 4'hA
`define SCICSL_LEN9 4'hB
`define SCICSL_PH_A 4'h7
`define SCICSL_PH_B 4'h8
`define SCICSL_PH_C 4'h9
`define SCICSL_IDLE8 8'hA0
`define SCICSL_IDLE9 8'hB0
`define SCICSL_ST_HUNT 2'h1
`define SCICSL_ST_RECV 2'h2
`endif

// [verification/scicsl_core_props.sv]
// Port-level checks for the serial control and status core.
module scicsl_core_props (
	input wire ref_clk_i,
	input wire rstn_i,
	input wire [2:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire tx_tick_i,
	input wire rx_tick_i,
	input wire rx_pin_i,
	input wire tx_pin_o,
	input wire tx_irq_o,
	input wire rx_irq_o,
	input wire err_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);
	sequence st_rd;
		rd_i && addr_i == 3'h3;
	endsequence
	chk_irq_reset: assert property ($rose(rstn_i) |-> !tx_irq_o && !rx_irq_o && !err_irq_o)
		else $error("irq after reset");
	chk_read_slot: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("stray read data");
	chk_done_empty: assert property (st_rd |=> !rdata_o[6] || rdata_o[7])
		else $error("done without empty");
	chk_done_line: assert property (st_rd |=> !rdata_o[6] || $past(tx_pin_o))
		else $error("done while line low");
	chk_tx_quiet: assert property (st_rd |=> rdata_o[7:6] != 2'b00 || !tx_irq_o)
		else $error("tx irq without flag");
	chk_rx_quiet: assert property (st_rd |=> rdata_o[5:4] != 2'b00 || !rx_irq_o)
		else $error("rx irq without flag");
	chk_err_quiet: assert property (st_rd |=> rdata_o[3:0] != 4'h0 || !err_irq_o)
		else $error("err irq without flag");
	chk_tick_align: assert property (!$past(tx_tick_i) |-> $stable(tx_pin_o))
		else $error("line moved off tick");
	cov_tx: cover property ($rose(tx_irq_o));
	cov_rx: cover property ($rose(rx_irq_o));
	cov_err: cover property ($rose(err_irq_o));
endmodule
bind scicsl_core scicsl_core_props u_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_tick_i(tx_tick_i),
	.rx_tick_i(rx_tick_i), .rx_pin_i(rx_pin_i), .tx_pin_o(tx_pin_o), .tx_irq_o(tx_irq_o),
	.rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));

// [verification/scicsl_core_tb.sv]
// Self-checking bench for the serial control and status core.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s %h %h", nm, e, g); end end
module scicsl_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, tx_tick_i = 0, rx_tick_i = 0, go = 0;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00, rdata_o, s, got_n, n;
	logic tx_pin_o, tx_irq_o, rx_irq_o, err_irq_o, rx_pin_i, busy;
	logic [11:0] frame = 12'hFFF;
	logic [3:0] len = 4'hA;
	logic [10:0] got;
	logic [4:0] ph = 5'h00;
	int bad_count = 0, n_tests = 0, cycles = 0;
	typedef struct packed {logic w; logic [2:0] a; logic [7:0] d; logic [7:0] m;} scicsl_row_t;
	scicsl_row_t rows [11] = '{'{0, 3, 8'hC0, 8'hFF}, '{0, 1, 8'h00, 8'hFF}, '{0, 2, 8'h00, 8'h0F},
		'{1, 1, 8'h0C, 8'h00}, '{0, 1, 8'h00, 8'hFF}, '{0, 7, 8'h00, 8'hFF}, '{1, 0, 8'h40, 8'h00},
		'{1, 1, 8'h0C, 8'h00}, '{0, 1, 8'h0C, 8'hFF}, '{1, 2, 8'h4F, 8'h00}, '{0, 2, 8'h4F, 8'h4F}};
	scicsl_core dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .tx_tick_i(tx_tick_i), .rx_tick_i(rx_tick_i), .rx_pin_i(rx_pin_i),
		.tx_pin_o(tx_pin_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
	scicsl_remote peer (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .rx_tick_i(rx_tick_i), .tx_tick_i(tx_tick_i),
		.tx_pin_i(tx_pin_o), .go_i(go), .frame_i(frame), .len_i(len), .line_o(rx_pin_i), .busy_o(busy),
		.got_o(got), .got_n_o(got_n));
	always #20 ref_clk_i = ~ref_clk_i;
	// Sixteen receive samples and one transmit tick per 32 clocks.
	always @(posedge ref_clk_i) begin
		ph <= ph + 5'h01;
		rx_tick_i <= ph[0];
		tx_tick_i <= ph == 5'h1F;
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 s = rdata_o;
	endtask
	task automatic send(input logic [11:0] f);
		frame = f;
		@(posedge ref_clk_i);
		go <= 1'b1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		repeat (600) @(posedge ref_clk_i) if (!busy) break;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			else begin
				rd(rows[i].a);
				`CHK("register", rows[i].d, s & rows[i].m)
			end
		end
		for (int k = 0; k < 2; k++) begin
			len = 4'hA + k[3:0];
			wr(3'h0, {3'b010, k[0], 4'h0});
			wr(3'h1, 8'h44);
			repeat (400) @(posedge ref_clk_i);
			@(posedge tx_tick_i);
			wr(3'h1, 8'h4C);
			rd(3'h3);
			wr(3'h4, 8'hC3);
			n = 0;
			while (tx_pin_o !== 1'b0 && n < 20) begin
				@(posedge ref_clk_i);
				n += tx_tick_i;
			end
			`CHK("preamble", 8'h0B + k[7:0], n)
			`CHK("tx irq busy", 1'b0, tx_irq_o)
			n = got_n;
			repeat (500) @(posedge ref_clk_i) if (got_n != n) break;
			`CHK("tx frame", {1'b0, k[0], 1'b1, 8'hC3}, got >> (12 - len))
			repeat (100) @(posedge ref_clk_i);
			`CHK("tx irq done", 1'b1, tx_irq_o)
		end
		wr(3'h0, 8'h40);
		len = 4'hA;
		wr(3'h1, 8'h34);
		send({3'b111, 8'h96, 1'b0});
		`CHK("rx irq", 1'b1, rx_irq_o)
		rd(3'h3);
		`CHK("rx full", 8'h20, s & 8'h3F)
		rd(3'h2);
		`CHK("ninth mirror", 1'b1, s[7])
		rd(3'h4);
		`CHK("rx data", 8'h96, s)
		rd(3'h3);
		`CHK("rx cleared", 8'h00, s & 8'h3F)
		repeat (400) @(posedge ref_clk_i);
		rd(3'h3);
		`CHK("idle", 8'h10, s & 8'h3F)
		`CHK("idle irq", 1'b1, rx_irq_o)
		rd(3'h4);
		repeat (400) @(posedge ref_clk_i);
		rd(3'h3);
		`CHK("idle disarmed", 8'h00, s & 8'h3F)
		wr(3'h0, 8'h50);
		len = 4'hB;
		send({3'b110, 8'hA1, 1'b0});
		rd(3'h3);
		rd(3'h2);
		`CHK("ninth", 1'b0, s[7])
		rd(3'h4);
		`CHK("rx data 9", 8'hA1, s)
		wr(3'h0, 8'h40);
		len = 4'hA;
		send({3'b111, 8'h11, 1'b0});
		rd(3'h3);
		send({3'b111, 8'h22, 1'b0});
		`CHK("overrun irq", 1'b1, err_irq_o)
		rd(3'h4);
		`CHK("kept byte", 8'h11, s)
		rd(3'h3);
		`CHK("overrun kept", 8'h08, s & 8'h3F)
		rd(3'h4);
		rd(3'h3);
		`CHK("overrun clear", 8'h00, s & 8'h3F)
		wr(3'h1, 8'h36);
		send({3'b111, 8'h33, 1'b0});
		`CHK("standby irq", 1'b0, rx_irq_o)
		rd(3'h3);
		`CHK("standby drop", 8'h00, s & 8'h20)
		repeat (400) @(posedge ref_clk_i);
		rd(3'h1);
		`CHK("standby wake", 1'b0, s[1])
		send({3'b110, 8'h5A, 1'b0});
		rd(3'h3);
		`CHK("framing", 8'h02, s & 8'h02)
		`CHK("framing irq", 1'b1, err_irq_o)
		wr(3'h1, 8'h74);
		rd(3'h4);
		`CHK("tx irq on", 1'b1, tx_irq_o)
		@(posedge tx_tick_i);
		wr(3'h1, 8'h4D);
		wr(3'h1, 8'h4C);
		n = 0;
		while (tx_pin_o !== 1'b0 && n < 8'h50) begin
			@(posedge ref_clk_i);
			n++;
		end
		`CHK("break first", 1'b1, n < 8'h40)
		n = 0;
		while (tx_pin_o !== 1'b1 && n < 8'h14) begin
			@(posedge ref_clk_i);
			n += tx_tick_i;
		end
		`CHK("break length", 8'h0A, n)
		wr(3'h0, 8'h00);
		rd(3'h3);
		`CHK("off flags", 2'b11, s[7:6])
		`CHK("off tx irq", 1'b0, tx_irq_o)
		print_verdict();
	end
endmodule

// [verification/scicsl_remote.sv]
// Remote serial node: sends frames on the receive pin and collects frames from the transmit pin.
module scicsl_remote (
	input wire ref_clk_i,
	input wire rstn_i,
	input wire rx_tick_i,
	input wire tx_tick_i,
	input wire tx_pin_i,
	input wire go_i,
	input wire [11:0] frame_i,
	input wire [3:0] len_i,
	output logic line_o,
	output logic busy_o,
	output logic [10:0] got_o,
	output logic [7:0] got_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] sh;
	logic [3:0] left, sub, rcnt;
	// Ones are shifted in behind the frame, so the line rests high between frames.
	always @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sh <= 12'hFFF;
			left <= 4'h0;
			sub <= 4'h0;
			rcnt <= 4'h0;
			got_o <= 11'h000;
			got_n_o <= 8'h00;
		end else begin
			if (go_i && left == 4'h0) begin
				sh <= frame_i;
				left <= len_i;
				sub <= 4'h0;
			end else if (rx_tick_i && left != 4'h0) begin
				sub <= sub + 4'h1;
				if (sub == 4'hF) begin
					sh <= {1'b1, sh[11:1]};
					left <= left - 4'h1;
				end
			end
			if (tx_tick_i && rcnt == 4'h0 && !tx_pin_i) begin
				rcnt <= len_i - 4'h1;
			end else if (tx_tick_i && rcnt != 4'h0) begin
				got_o <= {tx_pin_i, got_o[10:1]};
				rcnt <= rcnt - 4'h1;
				got_n_o <= got_n_o + {7'h00, rcnt == 4'h1};
			end
		end
	end
	assign line_o = sh[0];
	assign busy_o = left != 4'h0;
endmodule
